// >>> rtl/sbpt_defs.svh
// Operation
// - timer mode: count each instruction cycle to period value, wrap to zero
// - timer mode in idle: keep counting only while stop_in_idle (bit 13) is clear
// - timer mode, stop_in_idle set: freeze during idle, resume from held value
// - sync counter: count synchronised external rising edges, wrap after period match
// - sync counter in idle: continue if stop_in_idle clear, else halt then resume
// - async counter: count raw external rising edges, wrap after period value
// - async counter: stop during idle when stop_in_idle is set
// - interrupt on period match, or on gate falling edge in gated operation
// - mode, gating, prescaler and idle behaviour come from one 16-bit control word
// - usable as real-time clock time base or free-running 16-bit timer/counter
// - supports gated timing, selectable prescaler, idle and sleep operation
`ifndef SBPT_DEFS_SVH
`define SBPT_DEFS_SVH

`define SBPT_CTL_ON       15
`define SBPT_CTL_SIDL     13
`define SBPT_CTL_GATE     6
`define SBPT_CTL_PS_HI    5
`define SBPT_CTL_PS_LO    4
`define SBPT_CTL_SYNC     2
`define SBPT_CTL_EXT      1

`define SBPT_CNT_ZERO     16'h0000
`define SBPT_CNT_ONE      16'h0001

`define SBPT_PS_ZERO      8'h00
`define SBPT_PS_ONE       8'h01
`define SBPT_PS_TC_1      8'h00
`define SBPT_PS_TC_8      8'h07
`define SBPT_PS_TC_64     8'h3f
`define SBPT_PS_TC_256    8'hff

`endif

// >>> rtl/sbpt_pkg.sv
package sbpt_pkg;

   typedef enum logic [1:0] {
      SBPT_OFF   = 2'b00,
      SBPT_RUN   = 2'b01,
      SBPT_HOLD  = 2'b10,
      SBPT_SLEEP = 2'b11
   } sbpt_state_t;

   typedef enum logic [1:0] {
      SBPT_TIMER = 2'b00,
      SBPT_GATED = 2'b01,
      SBPT_SYNC  = 2'b10,
      SBPT_ASYNC = 2'b11
   } sbpt_mode_t;

   typedef enum logic [1:0] {
      SBPT_DIV1   = 2'b00,
      SBPT_DIV8   = 2'b01,
      SBPT_DIV64  = 2'b10,
      SBPT_DIV256 = 2'b11
   } sbpt_ps_t;

endpackage

// >>> rtl/sbpt_edge.sv
`include "sbpt_defs.svh"

module sbpt_edge (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic sig_in,
   input  wire logic sync_en,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic synced;
   logic raw_q;
   logic sync_q;

   // meta is read by the second stage only
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta   <= 1'b0;
         synced <= 1'b0;
         raw_q  <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta   <= sig_in;
         synced <= meta;
         raw_q  <= sig_in;
         sync_q <= synced;
      end
   end

   // raw path skips the synchroniser, so edges land two cycles earlier
   assign level = sync_en ? synced : sig_in;
   assign rise  = sync_en ? (synced & ~sync_q) : (sig_in & ~raw_q);
   assign fall  = sync_en ? (~synced & sync_q) : (~sig_in & raw_q);
endmodule

// >>> rtl/sbpt_prescale.sv
`include "sbpt_defs.svh"

module sbpt_prescale (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              clear,
   input  wire logic              tick_in,
   input  wire sbpt_pkg::sbpt_ps_t ratio,
   output logic                   tick_out
);
   import sbpt_pkg::*;

   logic [7:0] div_cnt;
   logic [7:0] term;
   logic       at_term;

   assign term = (ratio == SBPT_DIV8)   ? `SBPT_PS_TC_8   :
                 (ratio == SBPT_DIV64)  ? `SBPT_PS_TC_64  :
                 (ratio == SBPT_DIV256) ? `SBPT_PS_TC_256 : `SBPT_PS_TC_1;
   assign at_term  = (div_cnt >= term);
   assign tick_out = tick_in & at_term;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || clear) begin
         div_cnt <= `SBPT_PS_ZERO;
      end else if (tick_in) begin
         div_cnt <= at_term ? `SBPT_PS_ZERO : div_cnt + `SBPT_PS_ONE;
      end
   end
endmodule

// >>> rtl/sbpt_timer.sv
`include "sbpt_defs.svh"

module sbpt_timer (
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire logic [15:0]         first_timer_control_word,
   input  wire logic [15:0]         period_value,
   input  wire logic                count_load,
   input  wire logic [15:0]         count_load_value,
   input  wire logic                cpu_idle,
   input  wire logic                cpu_sleep,
   input  wire logic                ext_in,
   output logic [15:0]              count_value,
   output logic                     timer_irq,
   output sbpt_pkg::sbpt_state_t    run_state,
   output sbpt_pkg::sbpt_mode_t     active_mode,
   output logic                     gate_open
);
   import sbpt_pkg::*;

   // control word decode
   logic        tmr_on;
   logic        stop_in_idle;
   logic        gate_en;
   logic        sync_sel;
   logic        ext_sel;
   sbpt_ps_t    ps_sel;
   sbpt_mode_t  mode;

   assign tmr_on       = first_timer_control_word[`SBPT_CTL_ON];
   assign stop_in_idle = first_timer_control_word[`SBPT_CTL_SIDL];
   assign gate_en      = first_timer_control_word[`SBPT_CTL_GATE];
   assign sync_sel     = first_timer_control_word[`SBPT_CTL_SYNC];
   assign ext_sel      = first_timer_control_word[`SBPT_CTL_EXT];
   assign ps_sel       = sbpt_ps_t'(first_timer_control_word[`SBPT_CTL_PS_HI:`SBPT_CTL_PS_LO]);

   // gating only applies to the internal cycle source
   assign mode = ext_sel  ? (sync_sel ? SBPT_SYNC : SBPT_ASYNC) :
                 (gate_en ? SBPT_GATED : SBPT_TIMER);

   // external pin: clock in counter modes, gate in gated mode
   logic ext_level;
   logic ext_rise;
   logic ext_fall;
   logic use_sync;

   assign use_sync = (mode != SBPT_ASYNC);

   sbpt_edge u_edge (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .sig_in  (ext_in),
      .sync_en (use_sync),
      .level   (ext_level),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   // run state: idle with stop_in_idle freezes every mode; sleep halts the
   // instruction-clocked paths, while the async counter keeps running
   sbpt_state_t next_run_state;
   logic        idle_stop;
   logic        sleep_stop;

   assign idle_stop  = cpu_idle & stop_in_idle;
   assign sleep_stop = cpu_sleep & (mode != SBPT_ASYNC);

   always_comb begin
      next_run_state = run_state;
      case (run_state)
         SBPT_OFF: begin
            if (tmr_on) begin
               next_run_state = SBPT_RUN;
            end
         end
         SBPT_RUN: begin
            if (!tmr_on) begin
               next_run_state = SBPT_OFF;
            end else if (sleep_stop) begin
               next_run_state = SBPT_SLEEP;
            end else if (idle_stop) begin
               next_run_state = SBPT_HOLD;
            end
         end
         SBPT_HOLD: begin
            if (!tmr_on) begin
               next_run_state = SBPT_OFF;
            end else if (sleep_stop) begin
               next_run_state = SBPT_SLEEP;
            end else if (!idle_stop) begin
               next_run_state = SBPT_RUN;
            end
         end
         SBPT_SLEEP: begin
            if (!tmr_on) begin
               next_run_state = SBPT_OFF;
            end else if (!sleep_stop) begin
               next_run_state = idle_stop ? SBPT_HOLD : SBPT_RUN;
            end
         end
         default: begin
            next_run_state = SBPT_OFF;
         end
      endcase
   end

   // count source per mode
   logic src_tick;
   logic counting;
   logic ps_tick;
   logic ps_clear;

   assign counting = (run_state == SBPT_RUN) & (next_run_state == SBPT_RUN);
   assign src_tick = (mode == SBPT_TIMER) ? 1'b1 :
                     (mode == SBPT_GATED) ? ext_level :
                     ext_rise;
   // a mode change restarts the prescaler so the first period is clean; a ratio
   // change alone keeps the divider count, the >= compare stops it overrunning
   assign ps_clear = (run_state == SBPT_OFF) | (mode != active_mode);

   sbpt_prescale u_ps (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .clear    (ps_clear),
      .tick_in  (src_tick & counting),
      .ratio    (ps_sel),
      .tick_out (ps_tick)
   );

   // counter and period match
   logic [15:0] next_count;
   logic        at_period;
   logic        match_evt;
   logic        gate_evt;

   assign at_period  = (count_value == period_value);
   assign match_evt  = ps_tick & at_period;
   assign next_count = count_load ? count_load_value :
                       !ps_tick   ? count_value :
                       at_period  ? `SBPT_CNT_ZERO :
                       count_value + `SBPT_CNT_ONE;
   // gate end raises the request even if the period was not reached
   assign gate_evt   = (mode == SBPT_GATED) & counting & ext_fall;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         run_state   <= SBPT_OFF;
         active_mode <= SBPT_TIMER;
         count_value <= `SBPT_CNT_ZERO;
         timer_irq   <= 1'b0;
         gate_open   <= 1'b0;
      end else begin
         run_state   <= next_run_state;
         active_mode <= mode;
         count_value <= next_count;
         timer_irq   <= match_evt | gate_evt;
         gate_open   <= (mode == SBPT_GATED) & ext_level;
      end
   end
endmodule

// >>> testbench/sbpt_chk.sv
module sbpt_chk
   import sbpt_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic [15:0] first_timer_control_word,
   input wire logic [15:0] period_value,
   input wire logic        count_load,
   input wire logic [15:0] count_load_value,
   input wire logic        cpu_idle,
   input wire logic        cpu_sleep,
   input wire logic        ext_in,
   input wire logic [15:0] count_value,
   input wire logic        timer_irq,
   input wire sbpt_state_t run_state,
   input wire sbpt_mode_t  active_mode,
   input wire logic        gate_open
);
   logic [15:0] ctl;
   sbpt_mode_t  exp_mode;
   logic        run_ok;
   assign ctl = first_timer_control_word;
   assign exp_mode = !ctl[1] ? (ctl[6] ? SBPT_GATED : SBPT_TIMER) :
                     (ctl[2] ? SBPT_SYNC : SBPT_ASYNC);
   // only plain /1 timer steps are predictable cycle by cycle
   assign run_ok = ctl[15] && !cpu_idle && !cpu_sleep && !count_load && ctl[5:4] == 2'b00
      && exp_mode == SBPT_TIMER && run_state == SBPT_RUN && active_mode == SBPT_TIMER;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_timer_step: assert property (
      run_ok && count_value != period_value |=> count_value == $past(count_value) + 16'h0001)
      else $error("timer count did not step by one");
   chk_period_wrap: assert property (
      run_ok && count_value == period_value |=> count_value == 16'h0000 && timer_irq)
      else $error("period match did not wrap and interrupt");
   chk_hold_frozen: assert property (
      run_state == SBPT_HOLD && !count_load |=> $stable(count_value))
      else $error("count moved while held in idle");
   chk_idle_hold: assert property (
      run_state == SBPT_RUN && ctl[15] && ctl[13] && cpu_idle && !cpu_sleep
      |=> run_state == SBPT_HOLD) else $error("idle with stop bit did not hold");
   chk_off_state: assert property (
      !ctl[15] |=> run_state == SBPT_OFF) else $error("timer not off");
   chk_mode_decode: assert property (
      ctl[15] |=> active_mode == $past(exp_mode)) else $error("wrong mode decode");
   chk_irq_pulse: assert property (
      timer_irq |=> !timer_irq) else $error("interrupt longer than one cycle");
   chk_gate_closed: assert property (
      active_mode != SBPT_GATED && $past(active_mode) != SBPT_GATED |-> !gate_open)
      else $error("gate open outside gated mode");
   // the gate passes two synchroniser stages and the output flop
   chk_gate_follow: assert property (
      active_mode == SBPT_GATED |-> gate_open == $past(ext_in, 3))
      else $error("gate level not followed");
   chk_sleep_halt: assert property (
      ctl[15] && cpu_sleep && exp_mode != SBPT_ASYNC && run_state != SBPT_OFF
      |=> run_state == SBPT_SLEEP) else $error("sleep did not halt the timer");
endmodule

// >>> testbench/sbpt_src.sv
module sbpt_src #(
   parameter int HALF = 3
) (
   input wire logic ref_clk,
   input wire logic run,
   input wire logic level,
   output logic     ext_in
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial ext_in = 1'b0;
   // each level lasts HALF cycles so both sync and raw paths see every edge
   always @(negedge ref_clk) begin
      if (!run) begin
         ext_in <= level;
         n <= 0;
      end else if (n == HALF - 1) begin
         ext_in <= !ext_in;
         n <= 0;
      end else
         n <= n + 1;
   end
endmodule

// >>> testbench/sbpt_timer_tb_top.sv
module sbpt_timer_tb_top;
   import sbpt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] first_timer_control_word = 16'h0000;
   logic [15:0] period_value = 16'hffff;
   logic        count_load = 1'b0;
   logic [15:0] count_load_value = 16'h0000;
   logic        cpu_idle = 1'b0;
   logic        cpu_sleep = 1'b0;
   logic        ext_in;
   logic        src_run = 1'b0;
   logic        src_lvl = 1'b0;
   logic [15:0] count_value;
   logic        timer_irq;
   logic        gate_open;
   sbpt_state_t run_state;
   sbpt_mode_t  active_mode;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          sh[4] = '{0, 3, 6, 8};
   logic [15:0] irq_seen;
   logic [15:0] c0;
   always #20 ref_clk = ~ref_clk;
   sbpt_timer dut (.ref_clk, .sys_rst, .first_timer_control_word, .period_value, .count_load,
      .count_load_value, .cpu_idle, .cpu_sleep, .ext_in, .count_value, .timer_irq, .run_state,
      .active_mode, .gate_open);
   sbpt_src src (.ref_clk, .run(src_run), .level(src_lvl), .ext_in);
   task automatic cmp(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checks_done++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: got %h, want %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic run(input int n);
      irq_seen = 16'h0000;
      repeat (n) begin
         @(negedge ref_clk);
         if (timer_irq === 1'b1)
            irq_seen++;
      end
   endtask
   // edge counts are given a window because sync latency shifts the first edge
   task automatic scen(input logic [15:0] ctl, input logic idl, input logic slp, input logic sr,
      input logic lv, input int n, input logic [15:0] lo, input logic [15:0] hi);
      first_timer_control_word = ctl;
      cpu_idle = idl;
      cpu_sleep = slp;
      src_run = sr;
      src_lvl = lv;
      run(4);
      c0 = count_value;
      run(n);
      cmp(count_value - c0, lo, hi);
      $display("test %h done", ctl);
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      scen(16'h8000, 0, 0, 0, 0, 20, 20, 20);
      scen(16'h8000, 1, 0, 0, 0, 20, 20, 20);
      scen(16'ha000, 1, 0, 0, 0, 20, 0, 0);
      scen(16'ha000, 0, 0, 0, 0, 20, 20, 20);
      scen(16'h8006, 0, 0, 1, 0, 60, 9, 11);
      scen(16'ha006, 1, 0, 1, 0, 60, 0, 0);
      scen(16'h8006, 1, 0, 1, 0, 60, 9, 11);
      scen(16'h8002, 0, 0, 1, 0, 60, 9, 11);
      scen(16'ha002, 1, 0, 1, 0, 60, 0, 0);
      scen(16'h8000, 0, 1, 0, 0, 20, 0, 0);
      scen(16'h8002, 0, 1, 1, 0, 60, 9, 11);
      for (int i = 0; i < 4; i++) begin
         scen(16'h8000 | 16'(i << 4), 0, 0, 0, 0, 512,
              16'((512 >> sh[i]) - 1), 16'((512 >> sh[i]) + 1));
      end
      scen(16'h8040, 0, 0, 0, 1, 20, 18, 20);
      src_lvl = 1'b0;
      run(8);
      cmp(irq_seen, 1, 1);
      $display("test gate end done");
      scen(16'h8040, 0, 0, 0, 0, 20, 0, 0);
      scen(16'h0000, 0, 0, 0, 0, 20, 0, 0);
      first_timer_control_word = 16'h8000;
      run(4);
      count_load = 1'b1;
      period_value = 16'h0003;
      run(1);
      count_load = 1'b0;
      run(10);
      cmp(count_value, 2, 2);
      cmp(irq_seen, 2, 2);
      $display("test load done");
      final_report();
   end
   initial begin
      #1000000;
      error_cnt++;
      final_report();
   end
endmodule
bind sbpt_timer sbpt_chk chk (.ref_clk, .sys_rst, .first_timer_control_word, .period_value,
   .count_load, .count_load_value, .cpu_idle, .cpu_sleep, .ext_in, .count_value, .timer_irq,
   .run_state, .active_mode, .gate_open);
